// file: security_pkg.sv
// shared constants and types for the security attribution block
package security_pkg;
  localparam int unsigned num_regions    = 8;
  localparam int unsigned num_periph     = 16;
  localparam int unsigned num_gpio       = 16;
  localparam int unsigned num_irq        = 32;
  localparam int unsigned num_events     = 8;
  localparam int unsigned sram_blocks    = 64;
  localparam int unsigned sram_block_lsb = 9;
  localparam logic [31:0] code_ns_base   = 32'h0800_0000;
  localparam logic [31:0] code_nsc_base  = 32'h0C00_0000;
  localparam logic [31:0] code_nsc_end   = 32'h0FFF_FFFF;
  localparam logic [31:0] sram_ns_base   = 32'h2000_0000;
  localparam logic [31:0] sram_nsc_base  = 32'h3000_0000;
  localparam logic [31:0] sram_nsc_end   = 32'h3FFF_FFFF;
  localparam logic [31:0] per_ns_base    = 32'h4000_0000;
  localparam logic [31:0] per_nsc_base   = 32'h5000_0000;
  localparam logic [31:0] per_nsc_end    = 32'h5FFF_FFFF;
  localparam logic [31:0] sram_alias_msk = 32'h0FFF_FFFF;
  localparam logic [num_regions-1:0] region_en_reset  = '0;
  localparam logic [num_periph-1:0]  periph_sec_reset = '0;
  localparam logic [num_gpio-1:0]    gpio_sec_reset   = '1;
  localparam logic [num_irq-1:0]     irq_sec_reset    = '1;
  localparam logic [num_events-1:0]  ill_en_reset     = '0;
  localparam logic [sram_blocks-1:0] sram_sec_reset   = '1;

  typedef enum logic [1:0] {attr_ns, attr_nsc, attr_s} attr_e;
endpackage

// file: region_if.sv
// region configuration carried from top to the region matcher
`timescale 1ns/1ps
interface region_if;
  import security_pkg::*;
  logic [num_regions-1:0]       enable;
  logic [num_regions-1:0][26:0] base;
  logic [num_regions-1:0][26:0] limit;
  logic [num_regions-1:0]       nonsecure_callable;
  logic [31:0]                  addr;
  attr_e                        attr;
  modport cfg (output enable, output base, output limit, output nonsecure_callable, output addr, input attr);
  modport unit (input enable, input base, input limit, input nonsecure_callable, input addr, output attr);
endinterface

// file: attribution_unit.sv
// programmable attribution unit: region match for one address
`timescale 1ns/1ps
module attribution_unit
  import security_pkg::*;
(
  region_if.unit rif
);
  logic [num_regions-1:0] hit;

  // regions are 32-byte granular
  generate
    for (genvar i = 0; i < num_regions; i++)
    begin : g_reg
      assign hit[i] = rif.enable[i] && rif.addr[31:5] >= rif.base[i] && rif.addr[31:5] <= rif.limit[i];
    end
  endgenerate

  // lowest matching region wins; no match means secure
  always_comb
  begin
    rif.attr = attr_s;
    for (int i = num_regions - 1; i >= 0; i--)
    begin
      if (hit[i])
      begin
        rif.attr = rif.nonsecure_callable[i] ? attr_nsc : attr_ns;
      end
    end
  end
endmodule

// file: security_attribution.sv
// security attribution, aliasing, reset security state and illegal access reporting
`timescale 1ns/1ps
module security_attribution
  import security_pkg::*;
(
  // clock and reset
  input  wire logic                         mclk,
  input  wire logic                         rst,
  // option bytes
  input  wire logic                         global_security_enable_option,
  input  wire logic [31:0]                  secure_boot_addr,
  input  wire logic [31:0]                  flash_wm_start,
  input  wire logic [31:0]                  flash_wm_end,
  // secure configuration writes (ignored unless cfg_secure)
  input  wire logic                         cfg_secure,
  input  wire logic                         region_wr,
  input  wire logic [2:0]                   region_sel,
  input  wire logic                         region_enable,
  input  wire logic [26:0]                  region_base,
  input  wire logic [26:0]                  region_limit,
  input  wire logic                         region_nsc,
  input  wire logic                         periph_wr,
  input  wire logic [num_periph-1:0]        periph_sec_wdata,
  input  wire logic                         gpio_wr,
  input  wire logic [num_gpio-1:0]          gpio_sec_wdata,
  input  wire logic                         irq_wr,
  input  wire logic [num_irq-1:0]           irq_sec_wdata,
  input  wire logic                         ill_en_wr,
  input  wire logic [num_events-1:0]        ill_en_wdata,
  input  wire logic                         flash_blk_wr,
  input  wire logic                         flash_blk_wdata,
  input  wire logic                         sram_blk_wr,
  input  wire logic [5:0]                   sram_blk_sel,
  input  wire logic                         sram_blk_wdata,
  // attributed access from a bus master
  input  wire logic                         acc_valid,
  input  wire logic [31:0]                  acc_addr,
  input  wire logic                         acc_secure,
  input  wire logic                         acc_sram_ctl,
  input  wire logic [3:0]                   acc_periph,
  input  wire logic                         acc_aware_sec_reg,
  // external violation sources and flag clears
  input  wire logic [num_events-1:1]        ext_violation,
  input  wire logic [num_events-1:0]        ill_clear,
  // access result
  output logic                              acc_allow,
  output logic [1:0]                        acc_attr,
  output logic [31:0]                       acc_phys_addr,
  // state seen by the rest of the chip
  output logic                              cpu_secure,
  output logic [31:0]                       boot_addr,
  output logic [num_periph-1:0]             periph_secure,
  output logic [num_gpio-1:0]               gpio_secure,
  output logic [num_irq-1:0]                irq_target_secure,
  output logic                              flash_blk_secure,
  output logic [sram_blocks-1:0]            sram_blk_secure,
  output logic [num_events-1:0]             ill_flags,
  output logic                              ill_irq
);

  typedef struct packed {
    logic [num_regions-1:0]       reg_en;
    logic [num_regions-1:0][26:0] reg_base;
    logic [num_regions-1:0][26:0] reg_limit;
    logic [num_regions-1:0]       reg_nsc;
    logic [num_periph-1:0]        periph_sec;
    logic [num_gpio-1:0]          gpio_sec;
    logic [num_irq-1:0]           irq_sec;
    logic [num_events-1:0]        ill_en;
    logic [num_events-1:0]        ill_flag;
    logic                         flash_blk_sec;
    logic [sram_blocks-1:0]       sram_sec;
    logic                         allow;
    attr_e                        attr;
    logic [31:0]                  phys;
  } state_s;

  state_s     st;
  state_s     next_st;
  attr_e      fixed_attribution_map_attr;
  attr_e      final_attr;
  logic       violation;
  logic       in_flash_wm;
  logic [5:0] sram_idx;

  region_if rif ();

  assign rif.enable = st.reg_en;
  assign rif.base   = st.reg_base;
  assign rif.limit  = st.reg_limit;
  assign rif.nonsecure_callable    = st.reg_nsc;
  assign rif.addr   = acc_addr;

  attribution_unit u_unit (
    .rif (rif.unit)
  );

  // fixed map
  always_comb
  begin
    if ((acc_addr >= code_nsc_base && acc_addr <= code_nsc_end)
        || (acc_addr >= sram_nsc_base && acc_addr <= sram_nsc_end))
      fixed_attribution_map_attr = attr_nsc;
    else if (acc_addr >= per_nsc_base && acc_addr <= per_nsc_end)
      fixed_attribution_map_attr = attr_nsc;
    else
      fixed_attribution_map_attr = attr_ns;
  end

  // enum order makes the larger value the more secure one
  assign final_attr = (rif.attr > fixed_attribution_map_attr) ? rif.attr : fixed_attribution_map_attr;

  assign in_flash_wm = acc_addr >= flash_wm_start && acc_addr <= flash_wm_end;
  assign sram_idx    = acc_addr[sram_block_lsb +: 6];

  // nonsecure master reaching secure resources
  always_comb
  begin
    violation = 1'b0;
    if (global_security_enable_option && acc_valid && !acc_secure)
    begin
      if (final_attr == attr_s)
        violation = 1'b1;
      if (acc_addr >= code_nsc_base && acc_addr <= code_nsc_end && in_flash_wm)
        violation = 1'b1;
      if (acc_addr >= code_nsc_base && acc_addr <= code_nsc_end && !in_flash_wm && st.flash_blk_sec)
        violation = 1'b1;
      if ((acc_addr & ~sram_alias_msk) == sram_ns_base || (acc_addr & ~sram_alias_msk) == sram_nsc_base)
        violation = violation | st.sram_sec[sram_idx];
      if (acc_sram_ctl)
        violation = 1'b1;
      if ((acc_addr & ~sram_alias_msk) == per_ns_base || (acc_addr & ~sram_alias_msk) == per_nsc_base)
        violation = violation | st.periph_sec[acc_periph];
      if (acc_aware_sec_reg)
        violation = 1'b1;
    end
  end

  always_comb
  begin
    next_st       = st;
    next_st.allow = acc_valid && !violation;
    next_st.attr  = global_security_enable_option ? final_attr : attr_ns;
    // both aliases land on one physical resource
    next_st.phys  = acc_addr;
    if (acc_addr[31:28] == code_nsc_base[31:28] || acc_addr[31:28] == sram_nsc_base[31:28]
        || acc_addr[31:28] == per_nsc_base[31:28])
      next_st.phys = acc_addr & ~32'h0400_0000 & ~32'h1000_0000;
    if (violation)
      next_st.phys = '0;
    if (cfg_secure)
    begin
      if (region_wr)
      begin
        next_st.reg_en[region_sel]    = region_enable;
        next_st.reg_base[region_sel]  = region_base;
        next_st.reg_limit[region_sel] = region_limit;
        next_st.reg_nsc[region_sel]   = region_nsc;
      end
      if (periph_wr)
        next_st.periph_sec = periph_sec_wdata;
      if (gpio_wr)
        next_st.gpio_sec = gpio_sec_wdata;
      if (irq_wr)
        next_st.irq_sec = irq_sec_wdata;
      if (ill_en_wr)
        next_st.ill_en = ill_en_wdata;
      if (flash_blk_wr)
        next_st.flash_blk_sec = flash_blk_wdata;
      if (sram_blk_wr)
        next_st.sram_sec[sram_blk_sel] = sram_blk_wdata;
      next_st.ill_flag = st.ill_flag & ~ill_clear;
    end
    // set wins over clear
    next_st.ill_flag = next_st.ill_flag | {ext_violation, violation};
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st               <= '0;
      st.reg_en        <= region_en_reset;
      st.periph_sec    <= periph_sec_reset;
      st.gpio_sec      <= gpio_sec_reset;
      st.irq_sec       <= irq_sec_reset;
      st.ill_en        <= ill_en_reset;
      st.flash_blk_sec <= 1'b0;
      st.sram_sec      <= sram_sec_reset;
      st.attr          <= attr_ns;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign acc_allow         = st.allow;
  assign acc_attr          = st.attr;
  assign acc_phys_addr     = st.phys;
  assign cpu_secure        = global_security_enable_option;
  assign boot_addr         = secure_boot_addr;
  assign periph_secure     = st.periph_sec;
  assign gpio_secure       = st.gpio_sec;
  assign irq_target_secure = st.irq_sec;
  assign flash_blk_secure  = st.flash_blk_sec;
  assign sram_blk_secure   = st.sram_sec;
  assign ill_flags         = st.ill_flag;
  assign ill_irq           = |(st.ill_flag & st.ill_en);
endmodule

// file: security_attribution_asserts.sv
// concurrent checks on the attribution block ports
`timescale 1ns/1ps
module security_attribution_asserts
  import security_pkg::*;
(
  // clock, reset, controls
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        global_security_enable_option,
  input wire logic        cfg_secure,
  input wire logic        gpio_wr,
  input wire logic        acc_valid,
  input wire logic [31:0] acc_addr,
  input wire logic        acc_secure,
  // results and state
  input wire logic        acc_allow,
  input wire logic [1:0]  acc_attr,
  input wire logic [31:0] acc_phys_addr,
  input wire logic        cpu_secure,
  input wire logic [15:0] periph_secure,
  input wire logic [15:0] gpio_secure,
  input wire logic [31:0] irq_target_secure,
  input wire logic        flash_blk_secure,
  input wire logic [63:0] sram_blk_secure,
  input wire logic [7:0]  ill_flags,
  input wire logic        ill_irq
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  cpu_follows_option_a: assert property (cpu_secure == global_security_enable_option)
    else $error("cpu state differs from option");
  blocked_no_data_a: assert property (acc_valid ##1 !acc_allow |-> acc_phys_addr == 32'h0)
    else $error("blocked access leaked an address");
  blocked_reported_a: assert property (acc_valid && !acc_secure ##1 !acc_allow |-> ill_flags[0])
    else $error("blocked access not flagged");
  option_off_open_a: assert property (acc_valid && !global_security_enable_option
    |=> acc_allow && acc_attr == 2'h0)
    else $error("attribution applied with option clear");
  nsc_alias_floor_a: assert property (acc_valid && global_security_enable_option
    && acc_addr[31:28] inside {4'h3, 4'h5} |=> acc_attr != 2'h0)
    else $error("callable alias attributed nonsecure");
  irq_needs_flag_a: assert property (ill_flags == 8'h00 |-> !ill_irq)
    else $error("interrupt without a flagged event");
  reset_state_a: assert property ($fell(rst) |-> gpio_secure == '1 && irq_target_secure == '1
    && periph_secure == '0 && sram_blk_secure == '1 && !flash_blk_secure && ill_flags == 8'h00)
    else $error("wrong state after reset");
  unsecure_write_a: assert property (!cfg_secure && gpio_wr |=> $stable(gpio_secure))
    else $error("write taken without secure config");
endmodule

// file: access_master.sv
// bus master model issuing attributed accesses
`timescale 1ns/1ps
module access_master
(
  // clock
  input  wire logic        mclk,
  // access request
  output logic             acc_valid,
  output logic [31:0]      acc_addr,
  output logic             acc_secure
);
  initial
  begin
    acc_valid = 1'b0;
    acc_addr = 32'h0;
    acc_secure = 1'b1;
  end
  // idle address inverted so a stale value never looks valid
  task automatic access(input logic [31:0] a, input logic s);
    @(negedge mclk);
    {acc_valid, acc_addr, acc_secure} = {1'b1, a, s};
    @(negedge mclk);
    {acc_valid, acc_addr} = {1'b0, ~a};
  endtask
endmodule

// file: testbench.sv
// self-checking bench for the security attribution block
`timescale 1ns/1ps
module testbench;
  import security_pkg::*;
  logic        mclk, rst, global_security_enable_option, cfg_secure, region_wr, region_enable, region_nsc;
  logic        periph_wr, gpio_wr, irq_wr, ill_en_wr, flash_blk_wr, flash_blk_wdata, sram_blk_wr, sram_blk_wdata;
  logic        acc_valid, acc_secure, acc_allow, cpu_secure, flash_blk_secure, ill_irq, acc_sram_ctl;
  logic        acc_aware_sec_reg;
  logic [2:0]  region_sel;
  logic [26:0] region_base, region_limit;
  logic [15:0] periph_sec_wdata, gpio_sec_wdata, periph_secure, gpio_secure;
  logic [31:0] secure_boot_addr, flash_wm_start, flash_wm_end, irq_sec_wdata, acc_addr, acc_phys_addr;
  logic [31:0] boot_addr, irq_target_secure;
  logic [7:0]  ill_en_wdata, ill_clear, ill_flags;
  logic [7:1]  ext_violation;
  logic [5:0]  sram_blk_sel;
  logic [3:0]  acc_periph;
  logic [1:0]  acc_attr;
  logic [63:0] sram_blk_secure;
  int          bad_count, compares;
  logic [2:0]  rs [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
  logic [26:0] rb [4] = '{27'h040_0000, 27'h060_0000, 27'h100_0000, 27'h280_0000};
  logic [26:0] rl [4] = '{27'h05F_FFFF, 27'h07F_FFFF, 27'h17F_FFFF, 27'h2FF_FFFF};

  security_attribution u_security_attribution (.*);
  access_master u_access_master (.*);

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // expectation packs allow, attribute and physical address
  task automatic acc(input logic [31:0] a, input logic s, input logic [34:0] e);
    u_access_master.access(a, s);
    chk("access", {29'h0, e}, {29'h0, acc_allow, acc_attr, acc_phys_addr});
  endtask
  // strobes: region, periph, gpio, irq, ill_en, flash_blk, sram_blk
  task automatic pulse(input logic [6:0] m);
    @(negedge mclk);
    {region_wr, periph_wr, gpio_wr, irq_wr, ill_en_wr, flash_blk_wr, sram_blk_wr} = m;
    @(negedge mclk);
    {region_wr, periph_wr, gpio_wr, irq_wr, ill_en_wr, flash_blk_wr, sram_blk_wr} = 7'h00;
  endtask
  task automatic complete_run;
    $display("mismatches %0d, comparisons %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial
  begin
    repeat (3000) @(posedge mclk);
    bad_count++;
    complete_run();
  end
  initial
  begin
    {rst, global_security_enable_option, cfg_secure} = 3'b111;
    secure_boot_addr = 32'h0C00_0000;
    {region_wr, periph_wr, gpio_wr, irq_wr, ill_en_wr, flash_blk_wr, sram_blk_wr} = 7'h00;
    {region_sel, region_enable, region_base, region_limit, region_nsc, ill_en_wdata, ill_clear} = '0;
    {periph_sec_wdata, gpio_sec_wdata, irq_sec_wdata, flash_blk_wdata, sram_blk_sel, sram_blk_wdata} = '0;
    {flash_wm_start, flash_wm_end} = {32'h0C00_0000, 32'h0C00_0FFF};
    {acc_sram_ctl, acc_aware_sec_reg, acc_periph, ext_violation} = '0;
    bad_count = 0;
    compares = 0;
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    chk("periph", 64'h0, periph_secure);
    chk("irq_target", 64'hFFFF_FFFF, irq_target_secure);
    chk("sram_blk", '1, sram_blk_secure);
    chk("flags", 64'h0, {flash_blk_secure, ill_irq, ill_flags});
    chk("boot", 64'h1_0C00_0000, {cpu_secure, boot_addr});
    acc(32'h0800_0100, 1'b0, {1'b0, 2'h2, 32'h0});
    ill_en_wdata = 8'h01;
    pulse(7'h04);
    chk("ill_irq", 64'h101, {ill_irq, ill_flags});
    @(negedge mclk);
    {ill_clear, ext_violation} = {8'h01, 7'h04};
    @(negedge mclk);
    chk("ill_irq", 64'h008, {ill_irq, ill_flags});
    // event and clear on one flag in one cycle
    {ill_clear, ext_violation} = {8'h08, 7'h04};
    @(negedge mclk);
    chk("set_wins", 64'h008, {ill_irq, ill_flags});
    ext_violation = '0;
    @(negedge mclk);
    ill_clear = '0;
    chk("flag_clear", 64'h000, {ill_irq, ill_flags});
    acc(32'h0C00_0100, 1'b1, {1'b1, 2'h2, 32'h0800_0100});
    for (int i = 0; i < 4; i++)
    begin
      {region_sel, region_enable, region_base, region_limit} = {rs[i], 1'b1, rb[i], rl[i]};
      pulse(7'h40);
    end
    acc(32'h0800_0100, 1'b0, {1'b1, 2'h0, 32'h0800_0100});
    acc(32'h0C00_0100, 1'b1, {1'b1, 2'h1, 32'h0800_0100});
    acc(32'h5000_0010, 1'b1, {1'b1, 2'h1, 32'h4000_0010});
    acc(32'h3000_0040, 1'b0, {1'b0, 2'h2, 32'h0});
    acc(32'h0C00_0100, 1'b0, {1'b0, 2'h1, 32'h0});
    acc(32'h0C00_2000, 1'b0, {1'b1, 2'h1, 32'h0800_2000});
    acc(32'h5000_0010, 1'b0, {1'b1, 2'h1, 32'h4000_0010});
    acc_aware_sec_reg = 1'b1;
    acc(32'h5000_0010, 1'b0, {1'b0, 2'h1, 32'h0});
    acc(32'h5000_0010, 1'b1, {1'b1, 2'h1, 32'h4000_0010});
    {acc_aware_sec_reg, acc_sram_ctl} = 2'b01;
    acc(32'h5000_0100, 1'b0, {1'b0, 2'h1, 32'h0});
    acc_sram_ctl = 1'b0;
    acc(32'h2000_7E00, 1'b0, {1'b0, 2'h0, 32'h0});
    {cfg_secure, gpio_sec_wdata} = {1'b0, 16'h0F0F};
    pulse(7'h10);
    chk("gpio", 64'hFFFF, gpio_secure);
    {cfg_secure, periph_sec_wdata, irq_sec_wdata, flash_blk_wdata} = {1'b1, 16'h00A5, 32'h0000_FFFF, 1'b1};
    {sram_blk_sel, sram_blk_wdata} = {6'h3F, 1'b0};
    pulse(7'h3B);
    chk("config", 64'h1_00A5_0F0F, {flash_blk_secure, periph_secure, gpio_secure});
    chk("irq_target", 64'h0000_FFFF, irq_target_secure);
    chk("sram_blk", 64'h7FFF_FFFF_FFFF_FFFF, sram_blk_secure);
    acc(32'h0C00_2000, 1'b0, {1'b0, 2'h1, 32'h0});
    acc(32'h5000_0010, 1'b0, {1'b0, 2'h1, 32'h0});
    acc_periph = 4'h1;
    acc(32'h5000_0010, 1'b0, {1'b1, 2'h1, 32'h4000_0010});
    acc(32'h2000_7E00, 1'b0, {1'b1, 2'h0, 32'h2000_7E00});
    acc(32'h2000_7C00, 1'b0, {1'b0, 2'h0, 32'h0});
    // second reset must undo every configured attribute
    rst = 1'b1;
    @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    chk("reset_again", 64'h0_0000_FFFF, {flash_blk_secure, periph_secure, gpio_secure});
    chk("irq_again", 64'hFFFF_FFFF, irq_target_secure);
    chk("sram_again", '1, sram_blk_secure);
    acc(32'h2000_7E00, 1'b0, {1'b0, 2'h2, 32'h0});
    chk("ill_after", 64'h001, {ill_irq, ill_flags});
    global_security_enable_option = 1'b0;
    acc(32'h2000_0000, 1'b0, {1'b1, 2'h0, 32'h2000_0000});
    chk("cpu_off", 64'h0_0C00_0000, {cpu_secure, boot_addr});
    complete_run();
  end
endmodule

bind security_attribution security_attribution_asserts u_security_attribution_asserts (.*);
